// ### rtl/cid_defines.svh
// Purpose: Constants for the core instruction decode and execute block
// Assumes: 32-bit instruction words, APB byte addressing
// Notes:   Included by the core module and the core testbench
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

// Instruction word fields
`define CID_OPC_HI      31
`define CID_OPC_LO      26
`define CID_ZF_BIT      25
`define CID_CF_BIT      24
`define CID_WR_BIT      23
`define CID_IM_BIT      22
`define CID_COND_HI     21
`define CID_COND_LO     18
`define CID_DST_HI      17
`define CID_DST_LO      9
`define CID_SRC_HI      8
`define CID_SRC_LO      0
`define CID_COND_ALWAYS 4'hf

// Opcodes
`define CID_OP_MAG      6'h2a
`define CID_OP_INV      6'h29
`define CID_OP_INVC     6'h2c
`define CID_OP_INVNC    6'h2d
`define CID_OP_INVZ     6'h2e
`define CID_OP_INVNZ    6'h2f
`define CID_OP_CRL      6'h0d
`define CID_OP_CRR      6'h0c
`define CID_OP_MIR      6'h0f
`define CID_OP_ROTL     6'h09
`define CID_OP_ROTR     6'h08
`define CID_OP_ASR      6'h0e
`define CID_OP_SLL      6'h0b
`define CID_OP_SRL      6'h0a
`define CID_OP_SUB      6'h21
`define CID_OP_SUBMAG   6'h23
`define CID_OP_SSUB     6'h35
`define CID_OP_XSUB     6'h33
`define CID_OP_SXSUB    6'h37
`define CID_OP_SUM_C    6'h24
`define CID_OP_SUM_NC   6'h25
`define CID_OP_SUM_Z    6'h26
`define CID_OP_SUM_NZ   6'h27
`define CID_OP_OR       6'h1a
`define CID_OP_XOR      6'h1b
`define CID_OP_AND      6'h18
`define CID_OP_JNZ      6'h3a
`define CID_OP_JZ       6'h3b
`define CID_OP_HUB8     6'h00
`define CID_OP_HUB16    6'h01
`define CID_OP_HUB32    6'h02
`define CID_OP_WCNT     6'h3e
`define CID_OP_WPEQ     6'h3c
`define CID_OP_WPNE     6'h3d
`define CID_OP_WVID     6'h3f

// Clock counts minus one; a hub op's slot cycle is the first of its seven
`define CID_ALU_CLKS    3'h3
`define CID_FALL_CLKS   3'h7
`define CID_HUB_CLKS    3'h5
`define CID_WAIT_CLKS   3'h4

// APB register byte offsets
`define CID_REG_INSTR   8'h00
`define CID_REG_STATUS  8'h04
`define CID_REG_PC      8'h08
`define CID_REG_RFADDR  8'h0c
`define CID_REG_RFDATA  8'h10
`define CID_REG_COUNT   8'h14

// Status bits
`define CID_ST_BUSY     0
`define CID_ST_Z        1
`define CID_ST_C        2
`define CID_ST_TAKEN    3

`endif

// ### rtl/cid_pkg.sv
// Purpose: Types for the core instruction decode and execute block
// Assumes: Nothing
// Notes:   Offsets and counts live in cid_defines.svh
package cid_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_HUBW = 4'b0100,
    ST_WAIT = 4'b1000
  } cid_state_t;

  typedef enum logic [1:0] {
    CLS_ALU  = 2'h0,
    CLS_BR   = 2'h1,
    CLS_HUB  = 2'h2,
    CLS_WAIT = 2'h3
  } cid_cls_t;
endpackage

// ### rtl/cid_core.sv
// Purpose: Decode and execute one instruction at a time for a processor core
// Assumes: Hub arbiter pulses hub_slot once per 16 clocks; APB slave for issue
// Notes:   Software writes an instruction word to issue it
//
// Functional notes
// RULE_01: Word splits into opcode, four effect bits, condition, destination, source.
// RULE_02: Condition all ones always runs; effect bits choose flag and result writes.
// RULE_03: Hub instructions finish between 7 and 22 clocks after issue.
// RULE_04: The arbiter grants each core one slot every 16 clocks.
// RULE_05: Hub instruction stalls 0 to 15 clocks for slot, then 7 clocks.
// RULE_06: After hub access, 9 free clocks remain before the next slot.
// RULE_07: Modify-branch takes 4 clocks when jumping, 8 when falling through.
// RULE_08: Magnitude op writes absolute source, carry is source bit 31, 4 clocks.
// RULE_09: Magnitude op zero flag set exactly when source equals zero.
// RULE_10: Magnitude op carry set for negative source, cleared for positive.
// RULE_11: Suppressed result write still updates requested flags.
// RULE_12: Immediate bit makes source a 9-bit zero-extended literal.
// RULE_13: Invert-sign group writes result, zero on zero, carry source bit 31.
// RULE_14: Rotates and shifts decode as listed; left carry d31, right carry d0.
// RULE_15: Minus and minus-magnitude give borrow; signed minus gives underflow.
// RULE_16: Extended minus includes carry; zero needs old zero and zero result.
// RULE_17: Conditional sum adds or subtracts by flag; carry is signed overflow.
// RULE_18: OR and XOR write result, zero on zero, carry is parity.
// RULE_19: Test is AND with no result write; flags only.
// RULE_20: Test-jumps never write destination and return carry zero.
// RULE_21: Hub reads write fetched value and zero flag, hub timed.
// RULE_22: Hub writes share read codes without result write; no flags change.
// RULE_23: Wait ops take at least 5 clocks; only counter wait writes.
`timescale 1ns/1ns
`include "cid_defines.svh"

module cid_core #(
  parameter int RF_DEPTH = 512
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        hub_slot,
  input  wire  logic [31:0] hub_rdata,
  output logic              hub_req,
  output logic              hub_we,
  output logic       [1:0]  hub_size,
  output logic       [15:0] hub_addr,
  output logic       [31:0] hub_wdata,
  input  wire  logic [31:0] pins_in,
  input  wire  logic        vid_ready
);
  import cid_pkg::*;

  logic [31:0]      rf [RF_DEPTH];
  cid_pkg::cid_state_t state, next_state;
  logic [2:0]       cnt, next_cnt;
  logic [31:0]      ir, next_ir;
  logic             z, next_z, c, next_c, taken, next_taken;
  logic [8:0]       pc, next_pc, rf_addr, next_rf_addr;
  logic [31:0]      hub_data, next_hub_data, sys_cnt;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  logic             next_hub_req, next_hub_we;
  logic [1:0]       next_hub_size;
  logic [15:0]      next_hub_addr;
  logic [31:0]      next_hub_wdata;
  logic             apb_wr, issue, finish, exec_ok, wait_met, core_we, apb_rf_we;
  cid_pkg::cid_cls_t issue_cls;
  logic [5:0]       op, iop;
  logic [31:0]      d, s, res, idst;
  logic             zres, cres;

  // Decode of the word held in the instruction register
  assign op  = ir[`CID_OPC_HI:`CID_OPC_LO]; // RULE_01
  assign d   = rf[ir[`CID_DST_HI:`CID_DST_LO]];
  assign s   = ir[`CID_IM_BIT] ? {23'h0, ir[`CID_SRC_HI:`CID_SRC_LO]} // RULE_12
                               : rf[ir[`CID_SRC_HI:`CID_SRC_LO]];
  // Condition indexed by {c, z}; all ones runs always
  assign exec_ok = ir[`CID_COND_HI:`CID_COND_LO] == `CID_COND_ALWAYS // RULE_02
                   || ir[`CID_COND_LO + {c, z}];

  assign apb_wr = psel && penable && pready && pwrite;
  assign issue  = apb_wr && paddr == `CID_REG_INSTR && state == ST_IDLE;
  assign iop    = pwdata[`CID_OPC_HI:`CID_OPC_LO];
  assign idst   = rf[pwdata[`CID_DST_HI:`CID_DST_LO]];

  // Class of the word being issued picks its timing
  always_comb begin
    unique case (iop)
      `CID_OP_JNZ, `CID_OP_JZ:                 issue_cls = CLS_BR;
      `CID_OP_HUB8, `CID_OP_HUB16, `CID_OP_HUB32: issue_cls = CLS_HUB;
      `CID_OP_WCNT, `CID_OP_WPEQ, `CID_OP_WPNE, `CID_OP_WVID: issue_cls = CLS_WAIT;
      default:                                 issue_cls = CLS_ALU;
    endcase
  end

  always_comb begin
    unique case (op)
      `CID_OP_WCNT: wait_met = sys_cnt == d;
      `CID_OP_WPEQ: wait_met = (pins_in & s) == d;
      `CID_OP_WPNE: wait_met = (pins_in & s) != d;
      default:      wait_met = vid_ready;
    endcase
  end

  assign finish = (state == ST_EXEC && cnt == 3'h0)
                  || (state == ST_WAIT && cnt == 3'h0 && wait_met); // RULE_23

  // Arithmetic and logic results
  always_comb begin
    logic [32:0] w;
    logic [63:0] dd;
    logic [31:0] rv, mag, fill;
    logic [4:0]  sh;
    logic        inv_sel, sum_sub;
    w       = 33'h0;
    dd      = {d, d};
    rv      = 32'h0;
    sh      = s[4:0];
    mag     = s[31] ? 32'(-s) : s;
    fill    = 32'h0;
    inv_sel = 1'b0;
    sum_sub = 1'b0;
    res     = d;
    cres    = 1'b0;
    zres    = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rv[i] = d[31 - i];
    end
    unique case (op)
      `CID_OP_MAG: begin
        res  = mag; // RULE_08
        cres = s[31]; // RULE_10
      end
      `CID_OP_INV, `CID_OP_INVC, `CID_OP_INVNC, `CID_OP_INVZ, `CID_OP_INVNZ: begin
        unique case (op)
          `CID_OP_INV:   inv_sel = 1'b1;
          `CID_OP_INVC:  inv_sel = c;
          `CID_OP_INVNC: inv_sel = !c;
          `CID_OP_INVZ:  inv_sel = z;
          default:       inv_sel = !z;
        endcase
        res  = inv_sel ? 32'(-s) : s; // RULE_13
        cres = s[31];
      end
      `CID_OP_ROTL: begin
        dd   = dd << sh;
        res  = dd[63:32]; // RULE_14
        cres = d[31];
      end
      `CID_OP_ROTR: begin
        dd   = dd >> sh;
        res  = dd[31:0];
        cres = d[0];
      end
      `CID_OP_CRL: begin
        fill = c ? ~(32'hffffffff << sh) : 32'h0;
        res  = (d << sh) | fill;
        cres = d[31];
      end
      `CID_OP_CRR: begin
        fill = c ? ~(32'hffffffff >> sh) : 32'h0;
        res  = (d >> sh) | fill;
        cres = d[0];
      end
      `CID_OP_SLL: begin
        res  = d << sh;
        cres = d[31];
      end
      `CID_OP_SRL: begin
        res  = d >> sh;
        cres = d[0];
      end
      `CID_OP_ASR: begin
        res  = 32'($signed(d) >>> sh);
        cres = d[0];
      end
      `CID_OP_MIR: begin
        res  = rv >> sh;
        cres = d[0];
      end
      `CID_OP_SUB, `CID_OP_SUBMAG: begin
        w    = {1'b0, d} - {1'b0, (op == `CID_OP_SUBMAG) ? mag : s};
        res  = w[31:0];
        cres = w[32]; // RULE_15
      end
      `CID_OP_SSUB: begin
        w    = {1'b0, d} - {1'b0, s};
        res  = w[31:0];
        cres = (d[31] != s[31]) && (res[31] != d[31]);
      end
      `CID_OP_XSUB, `CID_OP_SXSUB: begin
        w    = {1'b0, d} - {1'b0, s} - {32'h0, c}; // RULE_16
        res  = w[31:0];
        cres = (op == `CID_OP_XSUB) ? w[32]
               : (d[31] != s[31]) && (res[31] != d[31]);
      end
      `CID_OP_SUM_C, `CID_OP_SUM_NC, `CID_OP_SUM_Z, `CID_OP_SUM_NZ: begin
        unique case (op)
          `CID_OP_SUM_C:  sum_sub = c;
          `CID_OP_SUM_NC: sum_sub = !c;
          `CID_OP_SUM_Z:  sum_sub = z;
          default:        sum_sub = !z;
        endcase
        res  = sum_sub ? d - s : d + s; // RULE_17
        cres = sum_sub ? (d[31] != s[31]) && (res[31] != d[31])
                       : (d[31] == s[31]) && (res[31] != d[31]);
      end
      `CID_OP_OR, `CID_OP_XOR, `CID_OP_AND: begin
        res  = (op == `CID_OP_OR) ? d | s : (op == `CID_OP_XOR) ? d ^ s : d & s;
        cres = ^res; // RULE_18 RULE_19
      end
      `CID_OP_JNZ, `CID_OP_JZ: begin
        res  = d;
        cres = 1'b0; // RULE_20
      end
      `CID_OP_HUB8, `CID_OP_HUB16, `CID_OP_HUB32: begin
        res  = hub_data; // RULE_21
        cres = c;
      end
      `CID_OP_WCNT: begin
        w    = {1'b0, d} + {1'b0, s};
        res  = w[31:0];
        cres = w[32]; // RULE_23
      end
      default: begin
        res  = d;
        cres = c;
      end
    endcase
    if (op == `CID_OP_MAG) begin
      zres = s == 32'h0; // RULE_09
    end else if (op == `CID_OP_XSUB || op == `CID_OP_SXSUB) begin
      zres = z && res == 32'h0;
    end else begin
      zres = res == 32'h0;
    end
  end

  // Hub writes carry no result write, so flags are left alone
  assign core_we   = finish && exec_ok && ir[`CID_WR_BIT]; // RULE_11
  assign apb_rf_we = apb_wr && paddr == `CID_REG_RFDATA && state == ST_IDLE;

  // Sequencer and flags
  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_ir       = ir;
    next_z        = z;
    next_c        = c;
    next_taken    = taken;
    next_pc       = pc;
    next_hub_data = hub_data;
    next_hub_req  = hub_req;
    next_hub_we   = hub_we;
    next_hub_size = hub_size;
    next_hub_addr = hub_addr;
    next_hub_wdata = hub_wdata;
    if (state == ST_IDLE && apb_wr && paddr == `CID_REG_STATUS) begin
      next_z = pwdata[`CID_ST_Z];
      next_c = pwdata[`CID_ST_C];
    end
    unique case (state)
      ST_IDLE: begin
        if (issue) begin
          next_ir    = pwdata;
          next_taken = 1'b0;
          unique case (issue_cls)
            CLS_BR: begin
              // Jump decided at issue so the short path costs nothing
              next_taken = (iop == `CID_OP_JNZ) == (idst != 32'h0);
              next_cnt   = next_taken ? `CID_ALU_CLKS : `CID_FALL_CLKS; // RULE_07
              next_state = ST_EXEC;
            end
            CLS_HUB: begin
              next_hub_req   = 1'b1; // RULE_05
              next_hub_we    = !pwdata[`CID_WR_BIT]; // RULE_22
              next_hub_size  = iop[1:0];
              next_hub_addr  = pwdata[`CID_IM_BIT] ? {7'h0, pwdata[8:0]}
                                                   : rf[pwdata[8:0]][15:0];
              next_hub_wdata = idst;
              next_state     = ST_HUBW;
            end
            CLS_WAIT: begin
              next_cnt   = `CID_WAIT_CLKS; // RULE_23
              next_state = ST_WAIT;
            end
            default: begin
              next_cnt   = `CID_ALU_CLKS; // RULE_08 RULE_13
              next_state = ST_EXEC;
            end
          endcase
        end
      end
      ST_HUBW: begin
        // Slot timing is the arbiter's; stall here until it comes round
        if (hub_slot) begin // RULE_04
          next_hub_req  = 1'b0;
          next_hub_data = hub_size == 2'h0 ? {24'h0, hub_rdata[7:0]}
                        : hub_size == 2'h1 ? {16'h0, hub_rdata[15:0]} : hub_rdata;
          next_cnt      = `CID_HUB_CLKS; // RULE_03 RULE_06
          next_state    = ST_EXEC;
        end
      end
      ST_EXEC, ST_WAIT: begin
        if (cnt != 3'h0) begin
          next_cnt = cnt - 3'h1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (finish) begin
      next_state = ST_IDLE;
      if (exec_ok) begin
        // Hub writes touch no flags; judged from the held word, not the bus
        if (ir[`CID_ZF_BIT] && (ir[`CID_WR_BIT]
            || !(op inside {`CID_OP_HUB8, `CID_OP_HUB16, `CID_OP_HUB32}))) begin
          next_z = zres; // RULE_02 RULE_22
        end
        if (ir[`CID_CF_BIT]) begin
          next_c = cres;
        end
        if (taken) begin
          next_pc = s[8:0];
        end
      end
    end
  end

  // APB slave: no wait cycle, data registered at setup
  always_comb begin
    next_pready  = psel && !penable && !pready;
    next_prdata  = 32'h0;
    next_pslverr = 1'b0;
    next_rf_addr = rf_addr;
    if (apb_wr && paddr == `CID_REG_RFADDR) begin
      next_rf_addr = pwdata[8:0];
    end
    if (psel && !penable) begin
      unique case (paddr)
        `CID_REG_INSTR:  next_prdata = ir;
        `CID_REG_STATUS: next_prdata = {28'h0, taken, c, z, state != ST_IDLE};
        `CID_REG_PC:     next_prdata = {23'h0, pc};
        `CID_REG_RFADDR: next_prdata = {23'h0, rf_addr};
        `CID_REG_RFDATA: next_prdata = rf[rf_addr];
        `CID_REG_COUNT:  next_prdata = sys_cnt;
        default:         next_pslverr = 1'b1;
      endcase
      // Issue and register-file writes refused while an instruction runs
      if (pwrite && state != ST_IDLE && (paddr == `CID_REG_INSTR
          || paddr == `CID_REG_RFDATA || paddr == `CID_REG_STATUS)) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      cnt       <= 3'h0;
      ir        <= 32'h0;
      z         <= 1'b0;
      c         <= 1'b0;
      taken     <= 1'b0;
      pc        <= 9'h0;
      rf_addr   <= 9'h0;
      hub_data  <= 32'h0;
      sys_cnt   <= 32'h0;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      hub_req   <= 1'b0;
      hub_we    <= 1'b0;
      hub_size  <= 2'h0;
      hub_addr  <= 16'h0;
      hub_wdata <= 32'h0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      ir        <= next_ir;
      z         <= next_z;
      c         <= next_c;
      taken     <= next_taken;
      pc        <= next_pc;
      rf_addr   <= next_rf_addr;
      hub_data  <= next_hub_data;
      sys_cnt   <= sys_cnt + 32'h1;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      hub_req   <= next_hub_req;
      hub_we    <= next_hub_we;
      hub_size  <= next_hub_size;
      hub_addr  <= next_hub_addr;
      hub_wdata <= next_hub_wdata;
    end
  end

  // Register file has no reset; a memory macro would not have one either
  always_ff @(posedge pclk) begin
    if (core_we) begin
      rf[ir[`CID_DST_HI:`CID_DST_LO]] <= res; // RULE_11
    end else if (apb_rf_we) begin
      rf[rf_addr] <= pwdata;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hub_after_slot: assert property ((state == ST_HUBW && hub_slot) |-> ##6 finish) // RULE_05
    else $error("hub instruction did not finish 6 clocks after slot");
  a_hub_total: assert property ((issue && issue_cls == CLS_HUB) |-> ##[7:22] finish) // RULE_03
    else $error("hub instruction outside 7 to 22 clocks");
  a_alu_four: assert property ((issue && issue_cls == CLS_ALU) |-> ##4 finish) // RULE_08
    else $error("plain instruction did not take 4 clocks");
  a_branch_time: assert property ((issue && issue_cls == CLS_BR) // RULE_07
      |-> (##4 finish) or (##8 finish))
    else $error("modify-branch did not take 4 or 8 clocks");
  a_wait_floor: assert property ((issue && issue_cls == CLS_WAIT) |-> ##1 !finish [*4]) // RULE_23
    else $error("wait finished in under 5 clocks");
  a_nr_no_write: assert property ((finish && !ir[`CID_WR_BIT]) // RULE_11
      |=> $stable(rf[ir[`CID_DST_HI:`CID_DST_LO]]))
    else $error("destination written with result write off");
  a_mag_zero: assert property ((finish && exec_ok && op == `CID_OP_MAG // RULE_09
      && ir[`CID_ZF_BIT]) |=> z == ($past(s) == 32'h0))
    else $error("magnitude op zero flag wrong");
  a_tj_carry: assert property ((finish && exec_ok && ir[`CID_CF_BIT] // RULE_20
      && (op == `CID_OP_JNZ || op == `CID_OP_JZ)) |=> !c)
    else $error("test-jump carry not zero");
  a_hubw_flags: assert property ((finish && op[5:2] == 4'h0 && hub_we) // RULE_22
      |=> $stable(z) && $stable(c))
    else $error("hub write changed flags");
  a_hub_req_drop: assert property ((hub_req && hub_slot) |=> !hub_req) // RULE_03
    else $error("hub request held past its slot");

  c_hub_done: cover property ((state == ST_HUBW && hub_slot) ##6 finish);
  c_br_taken: cover property (issue && issue_cls == CLS_BR ##4 finish);
  c_wait_done: cover property (state == ST_WAIT && finish);
  c_mag_minus: cover property (finish && op == `CID_OP_MAG && s[31]);
endmodule

// ### testbench/cid_hub_model.sv
// Purpose: Behavioural hub arbiter and shared memory facing one core
// Assumes: Long-aligned accesses; 64 longs of memory, zero at start
// Notes:   Byte and word writes store the whole long, a known limit
`timescale 1ns/1ns
module cid_hub_model #(
  parameter logic [3:0] PHASE = 4'h5
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hub_req,
  input  wire logic        hub_we,
  input  wire logic [15:0] hub_addr,
  input  wire logic [31:0] hub_wdata,
  output logic             hub_slot,
  output logic      [31:0] hub_rdata
);
  logic [3:0]  slot_cnt;
  logic [31:0] last_data;
  logic [31:0] mem [64];

  initial for (int i = 0; i < 64; i++) mem[i] = 32'h0;

  // Slot recurs every 16 clocks, blind to what the core runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt  <= PHASE;
      hub_slot  <= 1'b0;
      last_data <= 32'h0;
    end else begin
      slot_cnt  <= slot_cnt + 4'h1;
      hub_slot  <= (slot_cnt == 4'hf);
      last_data <= hub_rdata;
    end
  end

  always @(posedge pclk) begin
    if (hub_slot && hub_req && hub_we) mem[hub_addr[7:2]] <= hub_wdata;
  end

  // Outside a granted read the data lines toggle, so stale data never matches
  always_comb begin
    if (hub_slot && hub_req && !hub_we) hub_rdata = mem[hub_addr[7:2]];
    else hub_rdata = ~last_data;
  end
endmodule

// ### testbench/cid_core_test.sv
// Purpose: Self-checking bench for cid_core over APB with a hub model
// Assumes: No APB wait state; hub slot every 16 clocks
// Notes:   Register file entries 1 and 2 act as destination and source
`timescale 1ns/1ns
`include "cid_defines.svh"
module cid_core_test;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hub_slot;
  logic [31:0] hub_rdata;
  logic        hub_req;
  logic        hub_we;
  logic [1:0]  hub_size;
  logic [15:0] hub_addr;
  logic [31:0] hub_wdata;
  logic [31:0] pins_in;
  logic        vid_ready;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t_iss = 0;
  int          t_slot = 0;
  logic [3:0]  cnd = 4'hf;

  always #25 pclk = ~pclk;

  cid_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hub_slot(hub_slot), .hub_rdata(hub_rdata), .hub_req(hub_req),
    .hub_we(hub_we), .hub_size(hub_size), .hub_addr(hub_addr), .hub_wdata(hub_wdata),
    .pins_in(pins_in), .vid_ready(vid_ready));

  cid_hub_model HUB (.pclk(pclk), .presetn(presetn), .hub_req(hub_req), .hub_we(hub_we),
    .hub_addr(hub_addr), .hub_wdata(hub_wdata), .hub_slot(hub_slot), .hub_rdata(hub_rdata));

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Issue and slot edges, for hub timing
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && pwrite && paddr == `CID_REG_INSTR) t_iss <= cyc;
    if (hub_slot && hub_req) t_slot <= cyc;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  task automatic idle(output logic [31:0] v);
    do rd(`CID_REG_STATUS, v); while (v[0] !== 1'b0);
  endtask

  task automatic rf_rd(output logic [31:0] v);
    wr(`CID_REG_RFADDR, 32'h1);
    rd(`CID_REG_RFDATA, v);
  endtask

  // sl: 0 done by 4, 1 still busy at 5, 2 hub, 3 no probe, 4 busy probe only
  task automatic tc(input logic [5:0] op, input logic [3:0] ef, input logic [31:0] d, s,
                    input logic [1:0] cz, input logic [31:0] r, input logic [1:0] zc,
                    input int sl);
    logic [31:0] v;
    wr(`CID_REG_RFADDR, 32'h1);
    wr(`CID_REG_RFDATA, d);
    wr(`CID_REG_RFADDR, 32'h2);
    wr(`CID_REG_RFDATA, ef[0] ? ~s : s);
    wr(`CID_REG_STATUS, {29'h0, cz, 1'b0});
    wr(`CID_REG_INSTR, {op, ef, cnd, 9'h001, ef[0] ? s[8:0] : 9'h002});
    if (sl == 2) begin
      @(negedge pclk);
      while (t_slot <= t_iss) @(negedge pclk);
      chk(32'((t_slot - t_iss) inside {[1:16]}), 32'h1, "slot wait");
      chk(32'(hub_size), 32'(op[1:0]), "hub size");
      repeat (3) @(posedge pclk);
    end
    rd(`CID_REG_STATUS, v);
    if (sl != 3) chk(32'(v[0]), 32'h1, "busy after issue");
    rd(`CID_REG_STATUS, v);
    if (sl <= 2) chk(32'(v[0]), 32'(sl == 1), "busy probe");
    idle(v);
    chk(32'(v[2:1]), 32'(zc), "flags");
    rf_rd(v);
    chk(v, r, "result");
  endtask

  initial begin
    logic [31:0] v;
    logic        e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pins_in = 32'ha5;
    vid_ready = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CID_REG_STATUS, v);
    chk(v, 32'h0, "status after reset");
    tc(6'h2a, 4'he, 32'h0, 32'hffff_fffb, 2'b00, 32'h5, 2'b10, 0);
    tc(6'h2a, 4'he, 32'h7, 32'h0, 2'b00, 32'h0, 2'b01, 0);
    tc(6'h2a, 4'hc, 32'h1234, 32'h7, 2'b11, 32'h1234, 2'b00, 0);
    tc(6'h2a, 4'hf, 32'h0, 32'h1ff, 2'b11, 32'h1ff, 2'b00, 0);
    tc(6'h29, 4'he, 32'h0, 32'h3, 2'b00, 32'hffff_fffd, 2'b00, 0);
    tc(6'h2c, 4'he, 32'h0, 32'h3, 2'b10, 32'hffff_fffd, 2'b00, 0);
    tc(6'h2d, 4'he, 32'h0, 32'h3, 2'b10, 32'h3, 2'b00, 0);
    tc(6'h2e, 4'he, 32'h0, 32'h3, 2'b10, 32'h3, 2'b00, 0);
    tc(6'h2f, 4'he, 32'h0, 32'h3, 2'b10, 32'hffff_fffd, 2'b00, 0);
    tc(6'h0d, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h10, 2'b10, 0);
    tc(6'h0c, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h0800_0000, 2'b10, 0);
    tc(6'h0f, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h0800_0000, 2'b10, 0);
    tc(6'h09, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h18, 2'b10, 0);
    tc(6'h08, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h1800_0000, 2'b10, 0);
    tc(6'h0e, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'hf800_0000, 2'b10, 0);
    tc(6'h0b, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h10, 2'b10, 0);
    tc(6'h0a, 4'he, 32'h8000_0001, 32'h4, 2'b00, 32'h0800_0000, 2'b10, 0);
    tc(6'h21, 4'he, 32'h3, 32'h5, 2'b00, 32'hffff_fffe, 2'b10, 0);
    tc(6'h23, 4'he, 32'h3, 32'hffff_fffb, 2'b00, 32'hffff_fffe, 2'b10, 0);
    tc(6'h35, 4'he, 32'h8000_0000, 32'h1, 2'b00, 32'h7fff_ffff, 2'b10, 0);
    tc(6'h33, 4'he, 32'h5, 32'h4, 2'b11, 32'h0, 2'b01, 0);
    tc(6'h37, 4'he, 32'h5, 32'h4, 2'b10, 32'h0, 2'b00, 0);
    tc(6'h24, 4'he, 32'h7fff_ffff, 32'hffff_ffff, 2'b10, 32'h8000_0000, 2'b10, 0);
    tc(6'h25, 4'he, 32'h7fff_ffff, 32'hffff_ffff, 2'b10, 32'h7fff_fffe, 2'b00, 0);
    tc(6'h26, 4'he, 32'h7fff_ffff, 32'hffff_ffff, 2'b10, 32'h7fff_fffe, 2'b00, 0);
    tc(6'h27, 4'he, 32'h7fff_ffff, 32'hffff_ffff, 2'b10, 32'h8000_0000, 2'b10, 0);
    tc(6'h1a, 4'he, 32'h0f00, 32'h1, 2'b00, 32'h0f01, 2'b10, 0);
    tc(6'h1b, 4'he, 32'h3, 32'h3, 2'b10, 32'h0, 2'b01, 0);
    tc(6'h18, 4'hc, 32'h6, 32'h3, 2'b00, 32'h6, 2'b10, 0);
    tc(6'h3a, 4'h5, 32'h5, 32'h55, 2'b10, 32'h5, 2'b00, 0);
    rd(`CID_REG_PC, v);
    chk(v, 32'h55, "jump target");
    tc(6'h3b, 4'h5, 32'h5, 32'h55, 2'b10, 32'h5, 2'b00, 1);
    tc(6'h3c, 4'h1, 32'ha5, 32'hff, 2'b00, 32'ha5, 2'b00, 4);
    tc(6'h3d, 4'h1, 32'h0, 32'hff, 2'b00, 32'h0, 2'b00, 4);
    tc(6'h3f, 4'h1, 32'h9, 32'h3, 2'b00, 32'h9, 2'b00, 4);
    rd(`CID_REG_COUNT, v);
    tc(6'h3e, 4'he, v + 32'hc8, 32'hffff_ffff, 2'b00, v + 32'hc7, 2'b10, 4);
    cnd = 4'h0;
    tc(6'h2a, 4'he, 32'h9, 32'h3, 2'b00, 32'h9, 2'b00, 3);
    cnd = 4'hf;
    $display("test alu done");
    tc(6'h02, 4'hd, 32'h1234_5678, 32'h40, 2'b11, 32'h1234_5678, 2'b11, 2);
    tc(6'h02, 4'hb, 32'h0, 32'h40, 2'b00, 32'h1234_5678, 2'b00, 2);
    tc(6'h01, 4'hb, 32'h0, 32'h40, 2'b00, 32'h5678, 2'b00, 2);
    tc(6'h00, 4'hb, 32'h0, 32'h40, 2'b00, 32'h78, 2'b00, 2);
    tc(6'h02, 4'hb, 32'h7, 32'h44, 2'b00, 32'h0, 2'b01, 2);
    $display("test hub done");
    wr(`CID_REG_RFADDR, 32'h1);
    wr(`CID_REG_RFDATA, 32'h5a);
    wr(`CID_REG_INSTR, {6'h3c, 4'h1, 4'hf, 9'h001, 9'h0ff});
    apb(1'b1, `CID_REG_INSTR, 32'h0, v, e);
    chk(32'(e), 32'h1, "issue while busy");
    apb(1'b0, 8'h3c, 32'h0, v, e);
    chk(32'(e), 32'h1, "unmapped error");
    chk(v, 32'h0, "unmapped data");
    pins_in <= 32'h5a;
    idle(v);
    rf_rd(v);
    chk(v, 32'h5a, "pin wait no write");
    $display("test bus done");
    print_verdict();
  end
endmodule
